// File: core/art_timer_pkg.sv
// Constants, register map and state layout of the auto-reload PWM timer.
// Assumes an 8-bit register port with a 4-bit word address.
package art_timer_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int PWM_CHANNELS = 4;
	localparam int CAP_CHANNELS = 2;
	localparam int PRESC_W = 7;

	// Register word addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_COUNTER_ACCESS = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD_VALUE = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_PWM_CONTROL = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_DUTY_BASE = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_CTRL = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_VALUE0 = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_VALUE1 = 4'hA;

	// Control/status field positions
	localparam int CSR_EXT_CLOCK_BIT = 7;
	localparam int CSR_DIV_LSB = 4;
	localparam int CSR_RUN_BIT = 3;
	localparam int CSR_FORCE_BIT = 2;
	localparam int CSR_OVF_IE_BIT = 1;
	localparam int CSR_OVF_FLAG_BIT = 0;

	// PWM control field positions
	localparam int PWM_CONTROL_REG_OE_LSB = 4;
	localparam int PWM_CONTROL_REG_POL_LSB = 0;

	// Capture control/status field positions
	localparam int CAPCR_FLAG_LSB = 0;
	localparam int CAPCR_IE_LSB = 2;
	localparam int CAPCR_EDGE_LSB = 4;

	localparam logic [DATA_W-1:0] COUNTER_TOP = 8'hFF;
	localparam logic ECLK_CPU = 1'b0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic ext_clock_select;
		logic [2:0] divider_select;
		logic counter_run_enable;
		logic overflow_irq_enable;
		logic overflow_flag;
		logic [DATA_W-1:0] counter;
		logic [PRESC_W-1:0] prescaler;
		logic [DATA_W-1:0] reload_value;
		logic [PWM_CHANNELS-1:0] channel_output_enable;
		logic [PWM_CHANNELS-1:0] channel_polarity;
		logic [PWM_CHANNELS-1:0][DATA_W-1:0] duty_cycle;
		logic [PWM_CHANNELS-1:0][DATA_W-1:0] compare_shadow;
		logic [PWM_CHANNELS-1:0] pwm_level;
		logic [CAP_CHANNELS-1:0] capture_flag;
		logic [CAP_CHANNELS-1:0] capture_irq_enable;
		logic [CAP_CHANNELS-1:0] capture_edge_select;
		logic [CAP_CHANNELS-1:0][DATA_W-1:0] capture_value;
		logic [1:0] ext_sync;
		logic ext_prev;
		logic [CAP_CHANNELS-1:0] cap_sync_a;
		logic [CAP_CHANNELS-1:0] cap_sync_b;
		logic [CAP_CHANNELS-1:0] cap_prev;
		logic [DATA_W-1:0] rd_data;
	} timer_state_t;

	localparam timer_state_t STATE_RESET = '0;

endpackage : art_timer_pkg

// File: core/reload_pwm_timer.sv
// Auto-reload 8-bit timer with prescaler, four PWM outputs and two captures.
// Assumes a single-cycle register port on the CPU clock; pins are asynchronous.
// Overview of operation
// - Eight-bit counter advances once per prescaler output tick.
// - Counter access register reads and writes the live counter.
// - Overflow reloads counter from reload value; prescaler untouched.
// - Seven-bit prescaler; divider select picks divide by two to the n.
// - Prescaler input is CPU clock or external clock per select bit.
// - Run enable clear freezes prescaler and counter; set lets them count.
// - Reset clears counter, prescaler and selects CPU clock.
// - Force reload with run, or counter write, loads counter and clears prescaler.
// - Four hidden compare values copied from duty registers at each overflow.
// - Channel output enable makes its PWM pin a driven output.
// - PWM frequency is counter clock over 256 minus reload value.
// - Overflow drives polarity level; compare match restores opposite level.
// - PWM waveform generation halts in Halt mode.
// - Overflow sets sticky flag; request raised when its enable is set.
// - External clock counts 256 minus reload events, times two to the n, before overflow flag.
// - Capture edge latches counter into capture register and sets flag.
// - Edge select picks rising or falling; own interrupt enable per input.
// - Capture register locked until read; the read clears its flag.
// - Capture request stays high while a flag and its enable are set.
// - Capture inputs act as edge interrupts and can wake from Halt.
// - External clock select zero is CPU clock, one is external clock.
// - Overflow is the counter passing from FFh to the reload value.
// - Reading the control/status register clears the overflow flag.
// - Force reload bit is write-only and reads as zero.
`timescale 1ns/1ps

module reload_pwm_timer
	import art_timer_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire bus_req_t bus_req,
	output logic [DATA_W-1:0] rd_data,
	input wire logic external_count_clock,
	input wire logic [CAP_CHANNELS-1:0] capture_input_pin,
	input wire logic halt_mode,
	output logic [PWM_CHANNELS-1:0] pwm_output_pin,
	output logic [PWM_CHANNELS-1:0] pwm_output_oe,
	output logic overflow_irq,
	output logic capture_irq,
	output logic halt_wakeup
);

	timer_state_t state_reg;
	timer_state_t state_next;
	logic in_tick;
	logic count_tick;
	logic ovf_event;
	logic [PRESC_W-1:0] tap_mask;
	logic [CAP_CHANNELS-1:0] cap_edge;
	logic [CAP_CHANNELS-1:0] cap_event;
	logic [CAP_CHANNELS-1:0] cap_read;
	logic csr_read;
	logic load_counter;
	logic [DATA_W-1:0] counter_inc;

	always_comb begin
		state_next = state_reg;
		// Pin synchronisers; first stage feeds only the second
		state_next.ext_sync = {state_reg.ext_sync[0], external_count_clock};
		state_next.ext_prev = state_reg.ext_sync[1];
		state_next.cap_sync_a = capture_input_pin;
		state_next.cap_sync_b = state_reg.cap_sync_a;
		state_next.cap_prev = state_reg.cap_sync_b;

		// Prescaler input tick
		if (state_reg.ext_clock_select == ECLK_CPU) begin
			in_tick = state_reg.counter_run_enable;
		end else begin
			in_tick = state_reg.counter_run_enable & state_reg.ext_sync[1] & ~state_reg.ext_prev;
		end
		// Tap n fires when the low n prescaler bits are all ones
		tap_mask = PRESC_W'((8'h01 << state_reg.divider_select) - 8'h01);
		count_tick = in_tick & (&(state_reg.prescaler | ~tap_mask));
		ovf_event = count_tick & (state_reg.counter == COUNTER_TOP);
		counter_inc = state_reg.counter + 8'h01;

		csr_read = bus_req.rd & (bus_req.addr == ADDR_CTRL_STATUS);
		cap_read[0] = bus_req.rd & (bus_req.addr == ADDR_CAPTURE_VALUE0);
		cap_read[1] = bus_req.rd & (bus_req.addr == ADDR_CAPTURE_VALUE1);
		load_counter = 1'b0;

		if (in_tick) begin
			state_next.prescaler = state_reg.prescaler + 7'h01;
		end
		if (ovf_event) begin
			state_next.counter = state_reg.reload_value;
			state_next.compare_shadow = state_reg.duty_cycle;
		end else if (count_tick) begin
			state_next.counter = counter_inc;
		end

		// PWM levels, held still while halted
		if (!halt_mode) begin
			for (int i = 0; i < PWM_CHANNELS; i++) begin
				if (ovf_event) begin
					state_next.pwm_level[i] = state_reg.channel_polarity[i];
				end else if (count_tick && counter_inc == state_reg.compare_shadow[i]) begin
					// Match only reachable when compare exceeds reload or a value written to the counter
					state_next.pwm_level[i] = ~state_reg.channel_polarity[i];
				end
			end
		end

		// Overflow flag: the hardware set wins over the read clear
		state_next.overflow_flag = (state_reg.overflow_flag & ~csr_read) | ovf_event;

		// Captures
		for (int c = 0; c < CAP_CHANNELS; c++) begin
			cap_edge[c] = state_reg.capture_edge_select[c] ? (state_reg.cap_sync_b[c] & ~state_reg.cap_prev[c])
				: (~state_reg.cap_sync_b[c] & state_reg.cap_prev[c]);
			cap_event[c] = cap_edge[c] & (~state_reg.capture_flag[c] | cap_read[c]);
			if (cap_event[c]) begin
				state_next.capture_value[c] = state_reg.counter;
			end
			state_next.capture_flag[c] = (state_reg.capture_flag[c] & ~cap_read[c]) | cap_event[c];
		end

		// Register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				ADDR_CTRL_STATUS: begin
					state_next.ext_clock_select = bus_req.wdata[CSR_EXT_CLOCK_BIT];
					state_next.divider_select = bus_req.wdata[CSR_DIV_LSB +: 3];
					state_next.counter_run_enable = bus_req.wdata[CSR_RUN_BIT];
					state_next.overflow_irq_enable = bus_req.wdata[CSR_OVF_IE_BIT];
					if (bus_req.wdata[CSR_FORCE_BIT] && bus_req.wdata[CSR_RUN_BIT]) begin
						state_next.counter = state_reg.reload_value;
						load_counter = 1'b1;
					end
				end
				ADDR_COUNTER_ACCESS: begin
					state_next.counter = bus_req.wdata;
					load_counter = 1'b1;
				end
				ADDR_RELOAD_VALUE: begin
					state_next.reload_value = bus_req.wdata;
				end
				ADDR_PWM_CONTROL: begin
					state_next.channel_output_enable = bus_req.wdata[PWM_CONTROL_REG_OE_LSB +: PWM_CHANNELS];
					state_next.channel_polarity = bus_req.wdata[PWM_CONTROL_REG_POL_LSB +: PWM_CHANNELS];
				end
				ADDR_CAPTURE_CTRL: begin
					state_next.capture_irq_enable = bus_req.wdata[CAPCR_IE_LSB +: CAP_CHANNELS];
					state_next.capture_edge_select = bus_req.wdata[CAPCR_EDGE_LSB +: CAP_CHANNELS];
				end
				default: begin
					if (bus_req.addr >= ADDR_DUTY_BASE && bus_req.addr < ADDR_CAPTURE_CTRL) begin
						state_next.duty_cycle[bus_req.addr[1:0]] = bus_req.wdata;
					end
				end
			endcase
		end
		if (load_counter) begin
			state_next.prescaler = '0;
		end

		// Read data, valid the cycle after the strobe
		state_next.rd_data = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ADDR_CTRL_STATUS: begin
					// Force reload bit reads zero
					state_next.rd_data = {state_reg.ext_clock_select, state_reg.divider_select,
						state_reg.counter_run_enable, 1'b0, state_reg.overflow_irq_enable, state_reg.overflow_flag};
				end
				ADDR_COUNTER_ACCESS: begin
					state_next.rd_data = state_reg.counter;
				end
				ADDR_RELOAD_VALUE: begin
					state_next.rd_data = state_reg.reload_value;
				end
				ADDR_PWM_CONTROL: begin
					state_next.rd_data = {state_reg.channel_output_enable, state_reg.channel_polarity};
				end
				ADDR_CAPTURE_CTRL: begin
					state_next.rd_data = {2'b00, state_reg.capture_edge_select,
						state_reg.capture_irq_enable, state_reg.capture_flag};
				end
				ADDR_CAPTURE_VALUE0: begin
					state_next.rd_data = state_reg.capture_value[0];
				end
				ADDR_CAPTURE_VALUE1: begin
					state_next.rd_data = state_reg.capture_value[1];
				end
				default: begin
					if (bus_req.addr >= ADDR_DUTY_BASE && bus_req.addr < ADDR_CAPTURE_CTRL) begin
						state_next.rd_data = state_reg.duty_cycle[bus_req.addr[1:0]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data = state_reg.rd_data;
	assign pwm_output_pin = state_reg.pwm_level;
	assign pwm_output_oe = state_reg.channel_output_enable;
	assign overflow_irq = state_reg.overflow_flag & state_reg.overflow_irq_enable;
	assign capture_irq = |(state_reg.capture_flag & state_reg.capture_irq_enable);
	assign halt_wakeup = halt_mode & capture_irq;

	chk_ovf_reload: assert property (@(posedge clock) disable iff (sys_rst)
		ovf_event && !bus_req.wr |=> state_reg.counter == $past(state_reg.reload_value)
			&& state_reg.overflow_flag)
		else $error("overflow did not reload counter and set flag");

	chk_frozen_counter: assert property (@(posedge clock) disable iff (sys_rst)
		!state_reg.counter_run_enable && !bus_req.wr |=> $stable(state_reg.counter)
			&& $stable(state_reg.prescaler))
		else $error("counter moved while stopped");

	chk_access_load: assert property (@(posedge clock) disable iff (sys_rst)
		bus_req.wr && bus_req.addr == ADDR_COUNTER_ACCESS |=> state_reg.prescaler == 7'h00
			&& state_reg.counter == $past(bus_req.wdata))
		else $error("counter write did not load counter and clear prescaler");

	chk_cpu_divide_one: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg.counter_run_enable && state_reg.divider_select == 3'h0 && !state_reg.ext_clock_select
			&& state_reg.counter != COUNTER_TOP && !bus_req.wr
			|=> state_reg.counter == $past(state_reg.counter) + 8'h01)
		else $error("undivided cpu clock did not advance counter");

	chk_force_reads_zero: assert property (@(posedge clock) disable iff (sys_rst)
		bus_req.rd && bus_req.addr == ADDR_CTRL_STATUS |=> rd_data[CSR_FORCE_BIT] == 1'b0
			&& rd_data[CSR_OVF_FLAG_BIT] == $past(state_reg.overflow_flag))
		else $error("control read returned wrong bits");

	chk_ovf_read_clear: assert property (@(posedge clock) disable iff (sys_rst)
		csr_read && !ovf_event |=> !state_reg.overflow_flag)
		else $error("overflow flag survived a status read");

	chk_capture_lock: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg.capture_flag[0] && !cap_read[0] |=> $stable(state_reg.capture_value[0])
			&& state_reg.capture_flag[0])
		else $error("capture register changed while flagged");

	chk_capture_latch: assert property (@(posedge clock) disable iff (sys_rst)
		cap_event[1] |=> state_reg.capture_value[1] == $past(state_reg.counter)
			&& state_reg.capture_flag[1])
		else $error("capture did not latch counter");

	chk_pwm_polarity: assert property (@(posedge clock) disable iff (sys_rst)
		ovf_event && !halt_mode |=> pwm_output_pin == $past(state_reg.channel_polarity))
		else $error("overflow did not set pwm polarity level");

	chk_halt_pwm: assert property (@(posedge clock) disable iff (sys_rst)
		halt_mode |=> $stable(pwm_output_pin))
		else $error("pwm changed during halt");

	chk_capture_irq: assert property (@(posedge clock) disable iff (sys_rst)
		cap_event[0] && state_reg.capture_irq_enable[0] && !bus_req.wr |=> capture_irq [*2])
		else $error("capture request did not stay asserted");

endmodule : reload_pwm_timer

// File: test/pin_partner.sv
// Pin-side model of the timer: external count clock and the two capture pins.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps

module pin_partner (
	input wire logic clock,
	output logic ext_clk,
	output logic [1:0] cap_pin
);
	initial begin
		ext_clk = 1'b0;
		cap_pin = 2'h0;
	end

	// Event pulses, three cycles high then three low
	task automatic pulse(input int n);
		repeat (n) begin
			ext_clk <= 1'b1;
			repeat (3) @(posedge clock);
			ext_clk <= 1'b0;
			repeat (3) @(posedge clock);
		end
	endtask : pulse

	// Moves one capture pin, then waits out the synchroniser
	task automatic set_cap(input int ch, input logic v);
		cap_pin[ch] <= v;
		repeat (6) @(posedge clock);
	endtask : set_cap
endmodule : pin_partner

// File: test/tb_reload_pwm_timer.sv
// Self-checking bench for the auto-reload PWM timer.
// Assumes the register map and field layout of the timer package.
`timescale 1ns/1ps

module tb_reload_pwm_timer;
	import art_timer_pkg::*;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] exp;
	} row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic halt_mode = 1'b0;
	bus_req_t bus_req = '0;
	logic [DATA_W-1:0] rd_data;
	logic external_count_clock;
	logic [CAP_CHANNELS-1:0] capture_input_pin;
	logic [PWM_CHANNELS-1:0] pwm_output_pin;
	logic [PWM_CHANNELS-1:0] pwm_output_oe;
	logic overflow_irq;
	logic capture_irq;
	logic halt_wakeup;
	int fail_count = 0;
	int n_tests = 0;
	row_t rows [11] = '{
		'{ADDR_RELOAD_VALUE, 8'hF0, 8'hF0}, '{ADDR_PWM_CONTROL, 8'hF5, 8'hF5},
		'{4'h4, 8'hF2, 8'hF2}, '{4'h5, 8'hF4, 8'hF4}, '{4'h6, 8'hF6, 8'hF6}, '{4'h7, 8'hF8, 8'hF8},
		'{ADDR_COUNTER_ACCESS, 8'h5A, 8'h5A}, '{ADDR_CTRL_STATUS, 8'h06, 8'h02},
		'{4'hB, 8'hFF, 8'h00}, '{ADDR_CAPTURE_VALUE0, 8'h55, 8'h00}, '{ADDR_CAPTURE_CTRL, 8'h1F, 8'h1C}};

	always #5 clock = ~clock;

	reload_pwm_timer uut (.clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
		.external_count_clock(external_count_clock), .capture_input_pin(capture_input_pin),
		.halt_mode(halt_mode), .pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe),
		.overflow_irq(overflow_irq), .capture_irq(capture_irq), .halt_wakeup(halt_wakeup));

	pin_partner pins (.clock(clock), .ext_clk(external_count_clock), .cap_pin(capture_input_pin));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		bus_req <= '0;
		@(posedge clock);
	endtask : bus_write

	task automatic read_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		bus_req <= '0;
		#1 check(rd_data, exp);
		@(posedge clock);
	endtask : read_check

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1 check({pwm_output_oe, pwm_output_pin}, 8'h00);
		for (int a = 0; a < 11; a++) begin
			read_check(4'(a), 8'h00);
		end
		foreach (rows[i]) begin
			bus_write(rows[i].addr, rows[i].wdata);
			read_check(rows[i].addr, rows[i].exp);
		end
		check({4'h0, pwm_output_oe}, 8'h0F);
		// Sixteen input ticks at divider settings zero to three
		for (int n = 0; n < 4; n++) begin
			bus_write(ADDR_COUNTER_ACCESS, 8'h10);
			bus_write(ADDR_CTRL_STATUS, {1'b0, 3'(n), 4'h8});
			repeat (14) @(posedge clock);
			bus_write(ADDR_CTRL_STATUS, 8'h00);
			read_check(ADDR_COUNTER_ACCESS, 8'h10 + 8'(16 >> n));
		end
		bus_write(ADDR_CTRL_STATUS, 8'h0C);
		bus_write(ADDR_CTRL_STATUS, 8'h00);
		read_check(ADDR_COUNTER_ACCESS, 8'hF2);
		// Overflow with all channels enabled
		bus_write(ADDR_COUNTER_ACCESS, 8'hFD);
		bus_write(ADDR_CTRL_STATUS, 8'h0A);
		repeat (2) @(posedge clock);
		#1 check({overflow_irq, 3'h0, pwm_output_pin}, 8'h85);
		repeat (9) @(posedge clock);
		#1 check({4'h0, pwm_output_pin}, 8'h0A);
		read_check(ADDR_CTRL_STATUS, 8'h0B);
		bus_write(ADDR_CTRL_STATUS, 8'h02);
		read_check(ADDR_CTRL_STATUS, 8'h02);
		check({7'h00, overflow_irq}, 8'h00);
		read_check(ADDR_COUNTER_ACCESS, 8'hFC);
		// Overflow while halted leaves the pins alone
		halt_mode <= 1'b1;
		bus_write(ADDR_COUNTER_ACCESS, 8'hFF);
		bus_write(ADDR_CTRL_STATUS, 8'h08);
		repeat (2) @(posedge clock);
		#1 check({4'h0, pwm_output_pin}, 8'h0A);
		bus_write(ADDR_CTRL_STATUS, 8'h00);
		// Halted overflow still set the flag; this read clears it
		read_check(ADDR_CTRL_STATUS, 8'h01);
		// Captures on a frozen counter
		bus_write(ADDR_COUNTER_ACCESS, 8'h33);
		bus_write(ADDR_CAPTURE_CTRL, 8'h1C);
		pins.set_cap(0, 1'b1);
		check({6'h00, capture_irq, halt_wakeup}, 8'h03);
		halt_mode <= 1'b0;
		bus_write(ADDR_COUNTER_ACCESS, 8'h44);
		pins.set_cap(0, 1'b0);
		pins.set_cap(0, 1'b1);
		read_check(ADDR_CAPTURE_CTRL, 8'h1D);
		read_check(ADDR_CAPTURE_VALUE0, 8'h33);
		read_check(ADDR_CAPTURE_CTRL, 8'h1C);
		check({7'h00, capture_irq}, 8'h00);
		pins.set_cap(1, 1'b1);
		read_check(ADDR_CAPTURE_CTRL, 8'h1C);
		pins.set_cap(1, 1'b0);
		read_check(ADDR_CAPTURE_CTRL, 8'h1E);
		read_check(ADDR_CAPTURE_VALUE1, 8'h44);
		// Event counting from the external pin
		bus_write(ADDR_COUNTER_ACCESS, 8'hF0);
		bus_write(ADDR_CTRL_STATUS, 8'h8A);
		pins.pulse(15);
		check({7'h00, overflow_irq}, 8'h00);
		pins.pulse(1);
		check({7'h00, overflow_irq}, 8'h01);
		// Reset in mid-run clears all state
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1 check({overflow_irq, capture_irq, halt_wakeup, 1'b0, pwm_output_oe}, 8'h00);
		read_check(ADDR_COUNTER_ACCESS, 8'h00);
		read_check(ADDR_CTRL_STATUS, 8'h00);
		print_verdict();
	end
endmodule : tb_reload_pwm_timer
